// ==== ithh_host_port.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "ithh_consts.svh"
// ============================================================
module ithh_host_port
  import ithh_pkg::*;
#(
  parameter int unsigned SETTLE_CYCLES = `ITHH_SETTLE_CYCLES,
  parameter logic [14:0] SHUNT_DEFAULT = `ITHH_SHUNT_DEFAULT
)
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Host bus pins
  input wire logic [15:0] io_addr,
  input wire logic io_rd_n,
  input wire logic io_wr_n,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  output logic io_rdata_oe_n,
  // Address shunts, 1 = installed
  input wire logic [14:0] shunt_installed,
  // Coprocessor side
  output logic [7:0] cmd_byte,
  output logic cmd_valid,
  input wire logic cmd_take,
  input wire logic [7:0] resp_byte,
  input wire logic resp_load,
  input wire logic alarm_event,
  input wire logic alarm_clear,
  input wire logic board_fault,
  output logic soft_reset,
  // Indicator
  output logic fault_lamp
);
  // ============================================================
  // Pin synchronisers.
  logic [15:0] addr_s1;
  logic [15:0] addr_s2;
  logic [7:0] wdata_s1;
  logic [7:0] wdata_s2;
  logic [14:0] shunt_s1;
  logic [14:0] shunt_s2;
  logic [1:0] rd_s1;
  logic [1:0] wr_s1;
  logic rd_s2;
  logic wr_s2;
  logic rd_d;
  logic wr_d;
  always_ff @(posedge core_clk) begin
    addr_s1 <= io_addr;
    addr_s2 <= addr_s1;
    wdata_s1 <= io_wdata;
    wdata_s2 <= wdata_s1;
    shunt_s1 <= shunt_installed;
    shunt_s2 <= shunt_s1;
    rd_s1 <= {1'b0, ~io_rd_n};
    rd_s2 <= rd_s1[0];
    wr_s1 <= {1'b0, ~io_wr_n};
    wr_s2 <= wr_s1[0];
    rd_d <= rd_s2;
    wr_d <= wr_s2;
  end
  // ============================================================
  // Address decode.
  logic hit;
  ithh_addr_match u_match (
    .addr(addr_s2),
    .shunt_installed(shunt_s2),
    .hit(hit)
  );
  logic rd_start;
  logic wr_start;
  logic rd_end;
  logic is_ctrl;
  assign is_ctrl = addr_s2[0];
  assign rd_start = rd_s2 & ~rd_d & hit;
  assign wr_start = wr_s2 & ~wr_d & hit;
  assign rd_end = ~rd_s2 & rd_d;
  // ============================================================
  // Soft reset and settling.
  logic ctrl_write;
  logic any_reset;
  logic settling;
  assign ctrl_write = wr_start & (is_ctrl == `ITHH_OFS_CTRL);
  assign any_reset = ~resetn | soft_reset;
  ithh_settle_timer #(
    .CYCLES(SETTLE_CYCLES)
  ) u_settle (
    .core_clk(core_clk),
    .restart(any_reset),
    .busy(settling)
  );
  // ============================================================
  // Handshake state.
  ithh_flags_t flags;
  ithh_flags_t next_flags;
  logic [7:0] data_hold;
  logic [7:0] next_data_hold;
  logic [7:0] cmd_hold;
  logic [7:0] next_cmd_hold;
  logic next_soft_reset;
  logic reading_data;
  logic [7:0] next_rdata;
  logic next_oe_n;
  logic rd_active;
  logic next_rd_active;
  assign reading_data = rd_start & (is_ctrl == `ITHH_OFS_DATA);
  always_comb begin
    next_flags = flags;
    next_data_hold = data_hold;
    next_cmd_hold = cmd_hold;
    next_soft_reset = ctrl_write;
    next_rdata = io_rdata;
    next_oe_n = io_rdata_oe_n;
    next_rd_active = rd_active;
    if (wr_start && is_ctrl == `ITHH_OFS_DATA) begin
      next_cmd_hold = wdata_s2;
      next_flags.slot_empty = 1'b0;
    end else if (cmd_take) begin
      next_flags.slot_empty = 1'b1;
    end
    if (resp_load) begin
      next_data_hold = resp_byte;
      next_flags.byte_ready = 1'b1;
    end else if (reading_data) begin
      next_flags.byte_ready = 1'b0;
    end
    if (alarm_event) begin
      next_flags.alarm = 1'b1;
    end else if (alarm_clear) begin
      next_flags.alarm = 1'b0;
    end
    next_flags.fault = settling | board_fault;
    if (rd_start) begin
      next_rd_active = 1'b1;
      next_oe_n = 1'b0;
      if (is_ctrl == `ITHH_OFS_CTRL) begin
        next_rdata = {flags.slot_empty, flags.byte_ready,
                      flags.alarm, flags.fault, 4'h0};
      end else begin
        next_rdata = data_hold;
      end
    end else if (rd_end && rd_active) begin
      next_rd_active = 1'b0;
      next_oe_n = 1'b1;
    end
    if (any_reset) begin
      next_flags = '{slot_empty: 1'b1, byte_ready: 1'b0,
                     alarm: 1'b0, fault: 1'b1};
      next_data_hold = 8'h00;
      next_cmd_hold = 8'h00;
      next_rdata = 8'h00;
      next_oe_n = 1'b1;
      next_rd_active = 1'b0;
      if (!resetn) begin
        next_soft_reset = 1'b0;
      end
    end
  end
  always_ff @(posedge core_clk) begin
    flags <= next_flags;
    data_hold <= next_data_hold;
    cmd_hold <= next_cmd_hold;
    soft_reset <= next_soft_reset;
    io_rdata <= next_rdata;
    io_rdata_oe_n <= next_oe_n;
    rd_active <= next_rd_active;
    fault_lamp <= next_flags.fault;
    cmd_byte <= next_cmd_hold;
    cmd_valid <= ~next_flags.slot_empty;
  end
  // ============================================================
  // Checks.
  a_lamp_match: assert property (@(posedge core_clk) disable iff (!resetn)
    fault_lamp == flags.fault)
    else $error("lamp differs from fault flag");
  a_cmd_load: assert property (@(posedge core_clk) disable iff (!resetn)
    wr_start && !is_ctrl && !soft_reset |=> !flags.slot_empty)
    else $error("command write left slot empty");
  a_ready_set: assert property (@(posedge core_clk) disable iff (!resetn)
    resp_load && !soft_reset |=> flags.byte_ready)
    else $error("ready not set on response");
  a_alarm_set: assert property (@(posedge core_clk) disable iff (!resetn)
    alarm_event && !soft_reset |=> flags.alarm)
    else $error("alarm not raised");
  a_soft_reset: assert property (@(posedge core_clk) disable iff (!resetn)
    ctrl_write |=> soft_reset)
    else $error("control write gave no reset");
  a_fault_after: assert property (@(posedge core_clk) disable iff (!resetn)
    soft_reset |=> flags.fault [*2])
    else $error("fault not held after reset");
  a_status_read: assert property (@(posedge core_clk) disable iff (!resetn)
    rd_start && is_ctrl && !any_reset |=>
      io_rdata[`ITHH_BIT_FAULT] == $past(flags.fault))
    else $error("status byte fault bit wrong");
  a_data_read: assert property (@(posedge core_clk) disable iff (!resetn)
    rd_start && !is_ctrl && !any_reset |=> io_rdata == $past(data_hold))
    else $error("data read wrong");
  a_decode: assert property (@(posedge core_clk) disable iff (!resetn)
    rd_s2 && !rd_d && !hit && !rd_active |=> io_rdata_oe_n)
    else $error("unmatched address drove bus");
  // ============================================================
  // Factory base and settling checks.
  localparam logic [14:0] FACTORY_HI = 15'(`ITHH_BASE_DEFAULT >> 1);
  logic at_factory;
  logic [31:0] since_reset;
  logic [31:0] next_since_reset;
  assign at_factory = (shunt_s2 == SHUNT_DEFAULT);
  always_comb begin
    next_since_reset = since_reset;
    if (any_reset) begin
      next_since_reset = 32'h0;
    end else if (since_reset != 32'hFFFFFFFF) begin
      next_since_reset = since_reset + 32'h1;
    end
  end
  always_ff @(posedge core_clk) begin
    since_reset <= next_since_reset;
  end
  // ============================================================
  // Multi-step behaviour.
  sequence s_soft_pulse;
    soft_reset ##1 !soft_reset;
  endsequence : s_soft_pulse
  sequence s_read_open;
    !io_rdata_oe_n ##1 !io_rdata_oe_n;
  endsequence : s_read_open
  a_factory_base: assert property (
    @(posedge core_clk) disable iff (!resetn)
    at_factory |-> hit == (addr_s2[15:1] == FACTORY_HI))
    else $error("factory base not decoded");
  a_data_write: assert property (
    @(posedge core_clk) disable iff (!resetn)
    wr_start && !is_ctrl && !any_reset |=> cmd_byte == $past(wdata_s2))
    else $error("command byte not loaded");
  a_ready_clear: assert property (
    @(posedge core_clk) disable iff (!resetn)
    reading_data && !resp_load && !any_reset |=> !flags.byte_ready)
    else $error("ready not cleared by data read");
  a_slot_free: assert property (
    @(posedge core_clk) disable iff (!resetn)
    cmd_take && !wr_start && !any_reset |=> flags.slot_empty)
    else $error("slot not freed after take");
  a_alarm_clear: assert property (
    @(posedge core_clk) disable iff (!resetn)
    alarm_clear && !alarm_event && !any_reset |=> !flags.alarm)
    else $error("alarm not cleared");
  a_alarm_hold: assert property (
    @(posedge core_clk) disable iff (!resetn)
    !alarm_event && !alarm_clear && !any_reset |=> $stable(flags.alarm))
    else $error("alarm changed without cause");
  a_board_fault: assert property (
    @(posedge core_clk) disable iff (!resetn)
    board_fault && !any_reset |=> flags.fault)
    else $error("board fault not flagged");
  a_reset_flags: assert property (
    @(posedge core_clk) disable iff (!resetn)
    soft_reset |=> flags.slot_empty && !flags.byte_ready && !flags.alarm)
    else $error("soft reset left flags set");
  a_soft_pulse: assert property (
    @(posedge core_clk) disable iff (!resetn)
    ctrl_write |=> s_soft_pulse)
    else $error("soft reset not a single pulse");
  a_read_hold: assert property (
    @(posedge core_clk) disable iff (!resetn)
    rd_start && !any_reset |=> s_read_open)
    else $error("read data not held");
  a_status_bits: assert property (
    @(posedge core_clk) disable iff (!resetn)
    rd_start && is_ctrl && !any_reset |=>
      io_rdata[`ITHH_BIT_SLOT] == $past(flags.slot_empty) &&
      io_rdata[`ITHH_BIT_READY] == $past(flags.byte_ready) &&
      io_rdata[`ITHH_BIT_ALARM] == $past(flags.alarm))
    else $error("status flag bits wrong");
  a_status_low: assert property (
    @(posedge core_clk) disable iff (!resetn)
    rd_start && is_ctrl && !any_reset |=> io_rdata[3:0] == 4'h0)
    else $error("status low nibble not zero");
  a_oe_release: assert property (
    @(posedge core_clk) disable iff (!resetn)
    rd_end && rd_active && !rd_start && !any_reset |=> io_rdata_oe_n)
    else $error("bus not released after read");
  a_settle_min: assert property (
    @(posedge core_clk) disable iff (!resetn)
    $fell(flags.fault) |-> since_reset >= 32'(SETTLE_CYCLES))
    else $error("fault dropped before settling ended");
endmodule : ithh_host_port
`default_nettype wire

// ==== ithh_consts.svh ====
`ifndef ITHH_CONSTS_SVH
`define ITHH_CONSTS_SVH
// ============================================================
// Port offsets and status layout.
`define ITHH_OFS_DATA 1'b0
`define ITHH_OFS_CTRL 1'b1
`define ITHH_BIT_SLOT 7
`define ITHH_BIT_READY 6
`define ITHH_BIT_ALARM 5
`define ITHH_BIT_FAULT 4
// Factory shunt pattern for base 02B2: installed shunt reads 1.
`define ITHH_SHUNT_DEFAULT 15'h7EA6
`define ITHH_BASE_DEFAULT 16'h02B2
// Settling time after reset.
`define ITHH_SETTLE_MS 500
`define ITHH_CLK_MHZ 100
`define ITHH_SETTLE_CYCLES (`ITHH_SETTLE_MS * 1000 * `ITHH_CLK_MHZ)
`endif

// ==== ithh_pkg.sv ====
package ithh_pkg;
  // ============================================================
  // Types.
  typedef struct packed {
    logic slot_empty;
    logic byte_ready;
    logic alarm;
    logic fault;
  } ithh_flags_t;
  typedef enum logic [2:0] {
    ITHH_SETTLE = 3'h1,
    ITHH_RUN = 3'h2,
    ITHH_FAULTED = 3'h4
  } ithh_state_t;
endpackage : ithh_pkg

// ==== ithh_addr_match.sv ====
`timescale 1ns/1ns
`default_nettype none
module ithh_addr_match
  import ithh_pkg::*;
(
  // Address and shunts
  input wire logic [15:0] addr,
  input wire logic [14:0] shunt_installed,
  // Result
  output logic hit
);
  // ============================================================
  // Decode: installed needs bit 0, removed needs bit 1.
  assign hit = (addr[15:1] == ~shunt_installed);
endmodule : ithh_addr_match
`default_nettype wire

// ==== ithh_settle_timer.sv ====
`timescale 1ns/1ns
`default_nettype none
module ithh_settle_timer
  import ithh_pkg::*;
#(
  parameter int unsigned CYCLES = 50000000
)
(
  // Clock and restart
  input wire logic core_clk,
  input wire logic restart,
  // Status
  output logic busy
);
  logic [31:0] count;
  logic [31:0] next_count;
  always_comb begin
    next_count = count;
    if (restart) begin
      next_count = 32'(CYCLES);
    end else if (count != 32'h0) begin
      next_count = count - 32'h1;
    end
  end
  always_ff @(posedge core_clk) begin
    count <= next_count;
  end
  assign busy = (count != 32'h0);
endmodule : ithh_settle_timer
`default_nettype wire

// ==== ithh_host_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module ithh_host_model (
  // Clock
  input wire logic core_clk,
  // Host bus
  output logic [15:0] io_addr,
  output logic io_rd_n,
  output logic io_wr_n,
  output logic [7:0] io_wdata,
  input wire logic [7:0] io_rdata
);
  // ==========================================
  // Host bus cycles with status polling.
  logic [15:0] base = 16'h02B2;
  initial begin
    io_addr = 16'h0000;
    io_rd_n = 1'b1;
    io_wr_n = 1'b1;
    io_wdata = 8'h00;
  end
  task automatic cyc(input logic [15:0] a, input logic wr,
                     input logic [7:0] d, output logic [7:0] q);
    @(posedge core_clk);
    io_addr <= a;
    io_wdata <= d;
    if (wr) io_wr_n <= 1'b0;
    else io_rd_n <= 1'b0;
    repeat (6) @(posedge core_clk);
    q = io_rdata;
    io_wr_n <= 1'b1;
    io_rd_n <= 1'b1;
    io_wdata <= ~d;
    io_addr <= ~a;
    repeat (5) @(posedge core_clk);
  endtask : cyc
  task automatic stat(output logic [7:0] s);
    cyc(base + 16'h0001, 1'b0, 8'h00, s);
  endtask : stat
  task automatic send(input logic [7:0] d);
    logic [7:0] s;
    s = 8'h00;
    for (int i = 0; i < 50 && s[7] !== 1'b1; i++) stat(s);
    cyc(base, 1'b1, d, s);
  endtask : send
  task automatic recv(output logic [7:0] q);
    logic [7:0] s;
    s = 8'h00;
    for (int i = 0; i < 50 && s[6] !== 1'b1; i++) stat(s);
    cyc(base, 1'b0, 8'h00, q);
  endtask : recv
  task automatic settle();
    logic [7:0] s;
    s = 8'hFF;
    for (int i = 0; i < 50 && s[4] !== 1'b0; i++) stat(s);
  endtask : settle
endmodule : ithh_host_model
`default_nettype wire

// ==== ithh_host_port_tb.sv ====
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((e) !== (g)) begin \
  err_count++; $display("wrong value %s exp %0h got %0h", nm, e, g); end end
module ithh_host_port_tb;
  // ==========================================
  // Bench signals and reference state.
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic [14:0] shunt_installed = 15'h7EA6;
  logic [3:0] ev = 4'h0;
  logic board_fault = 1'b0;
  logic [7:0] resp_byte = 8'h00;
  logic [15:0] io_addr, b;
  logic io_rd_n, io_wr_n, cmd_valid, io_rdata_oe_n, soft_reset, fault_lamp;
  logic [7:0] io_wdata, io_rdata, cmd_byte, s, q, d;
  int err_count = 0;
  int n_compared = 0;
  int n_soft = 0;
  logic [7:0] resp_q[$];
  initial forever #5 core_clk = ~core_clk;
  always @(posedge core_clk) if (soft_reset === 1'b1) n_soft <= n_soft + 1;
  ithh_host_port #(.SETTLE_CYCLES(20)) u_ithh_host_port (
    .core_clk(core_clk), .resetn(resetn), .io_addr(io_addr),
    .io_rd_n(io_rd_n), .io_wr_n(io_wr_n), .io_wdata(io_wdata),
    .io_rdata(io_rdata), .io_rdata_oe_n(io_rdata_oe_n),
    .shunt_installed(shunt_installed), .cmd_byte(cmd_byte),
    .cmd_valid(cmd_valid), .cmd_take(ev[0]), .resp_byte(resp_byte),
    .resp_load(ev[1]), .alarm_event(ev[2]), .alarm_clear(ev[3]),
    .board_fault(board_fault), .soft_reset(soft_reset),
    .fault_lamp(fault_lamp));
  ithh_host_model u_ithh_host_model (
    .core_clk(core_clk), .io_addr(io_addr), .io_rd_n(io_rd_n),
    .io_wr_n(io_wr_n), .io_wdata(io_wdata), .io_rdata(io_rdata));
  task automatic pulse(input int i);
    @(posedge core_clk);
    ev[i] <= 1'b1;
    @(posedge core_clk);
    ev <= 4'h0;
  endtask : pulse
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : summarize
  // ==========================================
  // Scenarios.
  initial begin
    d = $urandom(32'h5A6B30B3);
    repeat (12) @(posedge core_clk);
    resetn <= 1'b1;
    @(posedge core_clk);
    #1 `CHK("lamp", 1'b1, fault_lamp)
    u_ithh_host_model.settle();
    `CHK("lamp", 1'b0, fault_lamp)
    for (int k = 0; k < 2; k++) begin
      if (k == 1) begin
        b = 16'($urandom) & 16'hFFFE;
        shunt_installed <= ~b[15:1];
        u_ithh_host_model.base = b;
      end
      d = 8'($urandom);
      u_ithh_host_model.send(d);
      `CHK("cmd", d, cmd_byte)
      `CHK("valid", 1'b1, cmd_valid)
      u_ithh_host_model.stat(s);
      `CHK("status", 8'h00, s & 8'hF0)
      pulse(0);
      u_ithh_host_model.cyc(u_ithh_host_model.base + 16'h2, 1'b1, d, q);
      u_ithh_host_model.cyc(u_ithh_host_model.base ^ 16'h8000, 1'b1, d, q);
      `CHK("valid", 1'b0, cmd_valid)
      `CHK("oe", 1'b1, io_rdata_oe_n)
      resp_q.push_back(8'($urandom));
      resp_byte <= resp_q[0];
      pulse(1);
      u_ithh_host_model.stat(s);
      `CHK("status", {1'b1, resp_q.size() != 0, 2'b00}, s[7:4])
      u_ithh_host_model.recv(q);
      `CHK("data", resp_q.pop_front(), q)
      u_ithh_host_model.stat(s);
      `CHK("status", 8'h80, s & 8'hF0)
    end
    pulse(2);
    u_ithh_host_model.stat(s);
    `CHK("status", 8'hA0, s & 8'hF0)
    pulse(3);
    u_ithh_host_model.stat(s);
    `CHK("status", 8'h80, s & 8'hF0)
    board_fault <= 1'b1;
    u_ithh_host_model.stat(s);
    `CHK("fault", 1'b1, s[4])
    `CHK("lamp", 1'b1, fault_lamp)
    board_fault <= 1'b0;
    u_ithh_host_model.settle();
    resp_byte <= 8'($urandom);
    pulse(1);
    u_ithh_host_model.cyc(u_ithh_host_model.base + 16'h1, 1'b1, 8'($urandom), q);
    `CHK("soft", 1, n_soft)
    `CHK("lamp", 1'b1, fault_lamp)
    u_ithh_host_model.settle();
    u_ithh_host_model.stat(s);
    `CHK("status", 8'h80, s & 8'hF0)
    summarize();
  end
  initial begin
    repeat (30000) @(posedge core_clk);
    err_count++;
    summarize();
  end
endmodule : ithh_host_port_tb
`default_nettype wire
